/* rtl/tsom_mux.sv */
`timescale 1ns/1ns
module tsom_mux
   import tsom_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [9:0] regAddr,
   input wire logic [7:0] regWdata,
   output logic [7:0] regRdata,
   input wire logic calDone,
   input wire logic [7:0] calBiasValue,
   input wire logic slicerOut,
   input wire logic limQ,
   input wire logic limI,
   input wire logic limQFilt,
   input wire logic limIFilt,
   input wire logic txBit,
   input wire logic paRampDone,
   input wire logic testDacBit,
   input wire logic defaultPin0,
   input wire logic defaultPin1,
   input wire logic defaultPin2,
   input wire logic defaultPin3,
   input wire logic defaultPin5,
   output logic generalPinZero,
   output logic generalPinOne,
   output logic generalPinTwo,
   output logic interruptSharedPinThree,
   output logic generalPinFive,
   output logic analogProbePinThreeEn,
   output logic testDacEn,
   output logic [3:0] testDacGain,
   output logic [3:0] sportMode,
   output logic sportEn
);

   // pins arriving from analog blocks: two-flop synchronisers, stage one read only by stage two
   logic [8:0] syncA;
   logic [8:0] syncB;
   logic [8:0] next_syncA;
   logic [8:0] next_syncB;
   logic calDoneA;
   logic calDoneB;
   logic [7:0] calValA;
   logic [7:0] calValB;
   logic next_calDoneA;
   logic next_calDoneB;
   logic [7:0] next_calValA;
   logic [7:0] next_calValB;

   // the bias word is taken per bit; the calibrator must hold it steady while its done flag is up
   always_comb begin
      next_syncA = {testDacBit, paRampDone, txBit, limIFilt, limQFilt, limI, limQ, slicerOut, 1'b0};
      next_syncB = syncA;
      next_calDoneA = calDone;
      next_calDoneB = calDoneA;
      next_calValA = calBiasValue;
      next_calValB = calValA;
   end

   // no reset on these flops: they flush within two clocks while srst is held
   always_ff @(posedge clk) begin
      syncA <= next_syncA;
      syncB <= next_syncB;
      calDoneA <= next_calDoneA;
      calDoneB <= next_calDoneB;
      calValA <= next_calValA;
      calValB <= next_calValB;
   end

   // software registers
   logic [7:0] analogProbeSelect;
   logic [7:0] strengthProbeMux;
   logic [7:0] pinFunctionSelect;
   logic [7:0] probeDacGain;
   logic [7:0] oscBiasCal;
   logic [7:0] next_analogProbeSelect;
   logic [7:0] next_strengthProbeMux;
   logic [7:0] next_pinFunctionSelect;
   logic [7:0] next_probeDacGain;
   logic [7:0] next_oscBiasCal;
   logic [7:0] next_regRdata;

   always_comb begin
      next_analogProbeSelect = analogProbeSelect;
      next_strengthProbeMux = strengthProbeMux;
      next_pinFunctionSelect = pinFunctionSelect;
      next_probeDacGain = probeDacGain;
      next_oscBiasCal = oscBiasCal;
      if (calDoneB) begin
         next_oscBiasCal = calValB;
      end
      if (regWrite) begin
         unique case (regAddr)
            ADDR_ANALOG_PROBE_SELECT: next_analogProbeSelect = regWdata;
            ADDR_STRENGTH_PROBE_MUX: next_strengthProbeMux = regWdata;
            ADDR_PIN_FUNCTION_SELECT: next_pinFunctionSelect = regWdata;
            ADDR_PROBE_DAC_GAIN: next_probeDacGain = regWdata;
            default: ; // readback register and other addresses ignore writes
         endcase
      end
      next_regRdata = regRdata;
      if (regRead) begin
         unique case (regAddr)
            ADDR_OSC_BIAS_CAL_READBACK: next_regRdata = oscBiasCal;
            ADDR_ANALOG_PROBE_SELECT: next_regRdata = analogProbeSelect;
            ADDR_STRENGTH_PROBE_MUX: next_regRdata = strengthProbeMux;
            ADDR_PIN_FUNCTION_SELECT: next_regRdata = pinFunctionSelect;
            ADDR_PROBE_DAC_GAIN: next_regRdata = probeDacGain;
            default: next_regRdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         analogProbeSelect <= RST_ANALOG_PROBE_SELECT;
         strengthProbeMux <= RST_STRENGTH_PROBE_MUX;
         pinFunctionSelect <= RST_PIN_FUNCTION_SELECT;
         probeDacGain <= RST_PROBE_DAC_GAIN;
         oscBiasCal <= RST_OSC_BIAS;
         regRdata <= 8'h00;
      end else begin
         analogProbeSelect <= next_analogProbeSelect;
         strengthProbeMux <= next_strengthProbeMux;
         pinFunctionSelect <= next_pinFunctionSelect;
         probeDacGain <= next_probeDacGain;
         oscBiasCal <= next_oscBiasCal;
         regRdata <= next_regRdata;
      end
   end

   // strength probe decode, shared by the routing logic and its checkers
   function automatic logic probeMatch(input logic [7:0] busSel, input logic [7:0] muxSel);
      return (busSel == PROBE_STRENGTH_BUS) && (muxSel[STRENGTH_SEL_MSB:0] == PROBE_STRENGTH_SEL);
   endfunction

   // serial port codes form one contiguous run; the mode index is the offset into it
   function automatic logic isSportCode(input logic [7:0] code);
      return (code >= PF_SPORT_FIRST) && (code <= PF_SPORT_LAST);
   endfunction

   // pin routing; outputs registered so pins never glitch on a code change
   logic next_pin0;
   logic next_pin1;
   logic next_pin2;
   logic next_pin3;
   logic next_pin5;
   logic next_probeEn;
   logic next_dacEn;
   logic [3:0] next_sportMode;
   logic next_sportEn;

   always_comb begin
      next_pin0 = defaultPin0;
      next_pin1 = defaultPin1;
      next_pin2 = defaultPin2;
      next_pin3 = defaultPin3;
      next_pin5 = defaultPin5;
      next_dacEn = 1'b0;
      next_sportEn = 1'b0;
      next_sportMode = SPORT_NONE;
      next_probeEn = probeMatch(analogProbeSelect, strengthProbeMux);
      case (pinFunctionSelect)
         PF_SLICER: next_pin5 = syncB[1];
         PF_LIMITER: begin
            next_pin0 = syncB[2];
            next_pin1 = syncB[3];
         end
         PF_LIMITER_FILT: begin
            next_pin0 = syncB[4];
            next_pin1 = syncB[5];
            next_pin2 = syncB[2];
            next_pin3 = syncB[3];
         end
         PF_TX_DATA: next_pin0 = syncB[6];
         PF_PA_RAMP: next_pin0 = syncB[7];
         PF_TEST_DAC: begin
            next_pin0 = syncB[8];
            next_dacEn = 1'b1;
         end
         default: begin
            if (isSportCode(pinFunctionSelect)) begin
               next_sportEn = 1'b1;
               next_sportMode = 4'(pinFunctionSelect - PF_SPORT_FIRST);
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         generalPinZero <= 1'b0;
         generalPinOne <= 1'b0;
         generalPinTwo <= 1'b0;
         interruptSharedPinThree <= 1'b0;
         generalPinFive <= 1'b0;
         analogProbePinThreeEn <= 1'b0;
         testDacEn <= 1'b0;
         testDacGain <= RST_PROBE_DAC_GAIN[DAC_GAIN_MSB:0];
         sportMode <= SPORT_NONE;
         sportEn <= 1'b0;
      end else begin
         generalPinZero <= next_pin0;
         generalPinOne <= next_pin1;
         generalPinTwo <= next_pin2;
         interruptSharedPinThree <= next_pin3;
         generalPinFive <= next_pin5;
         analogProbePinThreeEn <= next_probeEn;
         testDacEn <= next_dacEn;
         testDacGain <= probeDacGain[DAC_GAIN_MSB:0];
         sportMode <= next_sportMode;
         sportEn <= next_sportEn;
      end
   end

   // checkers; an attempt starting on the release edge still meets reset state, hence the !srst terms
   // probe follows selects
   a_probe_enable: assert property (@(posedge clk) disable iff (srst)
      !srst && probeMatch(analogProbeSelect, strengthProbeMux) |=> analogProbePinThreeEn)
      else $error("strength probe not enabled");
   a_probe_off: assert property (@(posedge clk) disable iff (srst)
      !srst && !probeMatch(analogProbeSelect, strengthProbeMux) |=> !analogProbePinThreeEn)
      else $error("strength probe enabled without both selects");
   a_cal_capture: assert property (@(posedge clk) disable iff (srst)
      !srst && calDoneB |=> oscBiasCal == $past(calValB))
      else $error("bias value not captured");
   a_cal_hold: assert property (@(posedge clk) disable iff (srst)
      !srst && !calDoneB |=> $stable(oscBiasCal))
      else $error("bias readback changed without calibration");
   a_cal_read: assert property (@(posedge clk) disable iff (srst)
      !srst && regRead && regAddr == ADDR_OSC_BIAS_CAL_READBACK |=> regRdata == $past(oscBiasCal))
      else $error("bias readback data wrong");
   a_slicer_route: assert property (@(posedge clk) disable iff (srst)
      pinFunctionSelect == PF_SLICER |=> generalPinFive == $past(syncB[1]))
      else $error("slicer not on pin five");
   a_limiter_route: assert property (@(posedge clk) disable iff (srst)
      pinFunctionSelect == PF_LIMITER |=> generalPinZero == $past(syncB[2]) && generalPinOne == $past(syncB[3]))
      else $error("limiter route wrong");
   a_filt_route: assert property (@(posedge clk) disable iff (srst)
      pinFunctionSelect == PF_LIMITER_FILT |=> generalPinTwo == $past(syncB[2]) && generalPinOne == $past(syncB[5])
      && interruptSharedPinThree == $past(syncB[3]) && generalPinZero == $past(syncB[4]))
      else $error("filtered limiter route wrong");
   a_tx_route: assert property (@(posedge clk) disable iff (srst)
      pinFunctionSelect == PF_TX_DATA |=> generalPinZero == $past(syncB[6]))
      else $error("transmit data not on pin zero");
   a_ramp_route: assert property (@(posedge clk) disable iff (srst)
      pinFunctionSelect == PF_PA_RAMP |=> generalPinZero == $past(syncB[7]))
      else $error("ramp flag not on pin zero");
   a_sport_mode: assert property (@(posedge clk) disable iff (srst)
      sportEn |-> sportMode == 4'($past(pinFunctionSelect) - PF_SPORT_FIRST))
      else $error("serial mode decode wrong");
   a_sport_enable: assert property (@(posedge clk) disable iff (srst)
      !srst && isSportCode(pinFunctionSelect) |=> sportEn)
      else $error("serial mode not enabled");
   a_sport_none: assert property (@(posedge clk) disable iff (srst)
      !srst && !isSportCode(pinFunctionSelect) |=> !sportEn && sportMode == SPORT_NONE)
      else $error("serial mode enabled by other code");
   a_dac_route: assert property (@(posedge clk) disable iff (srst)
      testDacEn |-> $past(pinFunctionSelect) == PF_TEST_DAC && generalPinZero == $past(syncB[8]))
      else $error("test DAC route wrong");
   a_dac_enable: assert property (@(posedge clk) disable iff (srst)
      !srst && pinFunctionSelect == PF_TEST_DAC |=> testDacEn)
      else $error("test DAC not enabled");
   a_dac_gain: assert property (@(posedge clk) disable iff (srst)
      !srst |=> testDacGain == 4'($past(probeDacGain)))
      else $error("test DAC gain not following register");
   a_default_pins: assert property (@(posedge clk) disable iff (srst)
      !srst && pinFunctionSelect == PF_DEFAULT |=> generalPinZero == $past(defaultPin0)
      && generalPinOne == $past(defaultPin1) && generalPinTwo == $past(defaultPin2)
      && interruptSharedPinThree == $past(defaultPin3) && generalPinFive == $past(defaultPin5)
      && !sportEn && !testDacEn)
      else $error("default pin function lost");

endmodule // tsom_mux

/* rtl/tsom_pkg.sv */
package tsom_pkg;
   // register addresses in the device's 10-bit register space
   localparam logic [9:0] ADDR_OSC_BIAS_CAL_READBACK = 10'h3DB;
   localparam logic [9:0] ADDR_ANALOG_PROBE_SELECT = 10'h3F8;
   localparam logic [9:0] ADDR_STRENGTH_PROBE_MUX = 10'h3F9;
   localparam logic [9:0] ADDR_PIN_FUNCTION_SELECT = 10'h3FA;
   localparam logic [9:0] ADDR_PROBE_DAC_GAIN = 10'h3FD;
   // reset values
   localparam logic [7:0] RST_ANALOG_PROBE_SELECT = 8'h00;
   localparam logic [7:0] RST_STRENGTH_PROBE_MUX = 8'h00;
   localparam logic [7:0] RST_PIN_FUNCTION_SELECT = 8'h00;
   localparam logic [7:0] RST_PROBE_DAC_GAIN = 8'h04;
   localparam logic [7:0] RST_OSC_BIAS = 8'h00;
   // field layouts
   localparam int STRENGTH_SEL_MSB = 1;
   localparam int DAC_GAIN_MSB = 3;
   // probe enable codes
   localparam logic [7:0] PROBE_STRENGTH_BUS = 8'h64;
   localparam logic [1:0] PROBE_STRENGTH_SEL = 2'h3;
   // pin function codes
   localparam logic [7:0] PF_DEFAULT = 8'h00;
   localparam logic [7:0] PF_SLICER = 8'h21;
   localparam logic [7:0] PF_LIMITER = 8'h40;
   localparam logic [7:0] PF_LIMITER_FILT = 8'h41;
   localparam logic [7:0] PF_TX_DATA = 8'h50;
   localparam logic [7:0] PF_PA_RAMP = 8'h53;
   localparam logic [7:0] PF_SPORT_FIRST = 8'hA0;
   localparam logic [7:0] PF_SPORT_LAST = 8'hA8;
   localparam logic [7:0] PF_TEST_DAC = 8'hC9;
   localparam logic [3:0] SPORT_NONE = 4'hF;
endpackage

/* test/testbench.sv */
`timescale 1ns/1ns
`define CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin badCount++; $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module testbench;
   import tsom_pkg::*;
   logic clk = 0, srst = 1, regWrite = 0, regRead = 0, calDone = 0;
   logic [9:0] regAddr = 0;
   logic [7:0] regWdata = 0, regRdata, calBiasValue = 0, src = 0, d, s;
   logic [4:0] dflt = 0;
   logic [3:0] testDacGain, sportMode;
   logic analogProbePinThreeEn, testDacEn, sportEn, sEn;
   logic [4:0] pins;
   logic [7:0] m [logic [9:0]];
   logic [7:0] codes [$] = '{8'h00, 8'h21, 8'h40, 8'h41, 8'h50, 8'h53, 8'hC9, 8'h22, 8'h7F, 8'hA9, 8'h9F, 8'hFF};
   logic [9:0] addrs [$] = '{10'h3DB, 10'h3F8, 10'h3F9, 10'h3FA, 10'h3FD, 10'h3FB, 10'h000};
   int badCount = 0, totalChecks = 0;

   tsom_mux tsom_mux_inst (.clk(clk), .srst(srst), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
      .regWdata(regWdata), .regRdata(regRdata), .calDone(calDone), .calBiasValue(calBiasValue),
      .slicerOut(src[0]), .limQ(src[1]), .limI(src[2]), .limQFilt(src[3]), .limIFilt(src[4]), .txBit(src[5]),
      .paRampDone(src[6]), .testDacBit(src[7]), .defaultPin0(dflt[0]), .defaultPin1(dflt[1]),
      .defaultPin2(dflt[2]), .defaultPin3(dflt[3]), .defaultPin5(dflt[4]), .generalPinZero(pins[0]),
      .generalPinOne(pins[1]), .generalPinTwo(pins[2]), .interruptSharedPinThree(pins[3]),
      .generalPinFive(pins[4]), .analogProbePinThreeEn(analogProbePinThreeEn), .testDacEn(testDacEn),
      .testDacGain(testDacGain), .sportMode(sportMode), .sportEn(sportEn));

   // free-running 50 MHz clock
   initial begin
      forever #10 clk = ~clk;
   end

   // reference pin routing: unlisted codes keep the normal pin function
   function automatic logic [4:0] expPins(input logic [7:0] c);
      logic [4:0] e;
      e = dflt;
      case (c)
         8'h21: e[4] = src[0];
         8'h40: e[1:0] = {src[2], src[1]};
         8'h41: e[3:0] = {src[2], src[1], src[4], src[3]};
         8'h50: e[0] = src[5];
         8'h53: e[0] = src[6];
         8'hC9: e[0] = src[7];
         default: ;
      endcase
      return e;
   endfunction

   // one write cycle; the model drops writes to read-only or unmapped places
   task automatic wr(input logic [9:0] a, input logic [7:0] v);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= v;
      @(posedge clk);
      regWrite <= 1'b0;
      if (m.exists(a) && a != ADDR_OSC_BIAS_CAL_READBACK) m[a] = v;
   endtask

   // one read cycle, data compared on the falling edge after the edge that samples the read
   task automatic rd(input logic [9:0] a);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      @(negedge clk);
      `CHK(regRdata, (m.exists(a) ? m[a] : 8'h00))
   endtask

   // model registers at their reset values
   task automatic modelReset;
      m[ADDR_OSC_BIAS_CAL_READBACK] = RST_OSC_BIAS;
      m[ADDR_ANALOG_PROBE_SELECT] = RST_ANALOG_PROBE_SELECT;
      m[ADDR_STRENGTH_PROBE_MUX] = RST_STRENGTH_PROBE_MUX;
      m[ADDR_PIN_FUNCTION_SELECT] = RST_PIN_FUNCTION_SELECT;
      m[ADDR_PROBE_DAC_GAIN] = RST_PROBE_DAC_GAIN;
   endtask

   task automatic printVerdict;
      $display("comparisons %0d mismatches %0d", totalChecks, badCount);
      if (badCount == 0 && totalChecks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // hang guard: the whole run is far shorter than this
   initial begin
      repeat (20000) @(posedge clk);
      badCount++;
      printVerdict();
   end

   initial begin
      void'($urandom(71249));
      modelReset();
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      @(negedge clk);
      `CHK(({testDacGain, sportMode, sportEn, analogProbePinThreeEn, testDacEn}), ({4'h4, 4'hF, 3'h0}))
      `CHK(pins, 5'h00)
      // reset values, then random traffic including read-only and unmapped places
      foreach (addrs[i]) rd(addrs[i]);
      for (int i = 0; i < 14; i++) begin
         d = addrs[i % 7] == ADDR_PIN_FUNCTION_SELECT ? 8'h00 : 8'($urandom);
         wr(addrs[i % 7], d);
         rd(addrs[i % 7]);
      end
      // calibration capture holds after the calibrator lets go
      @(posedge clk);
      d = 8'($urandom);
      calBiasValue <= d;
      calDone <= 1'b1;
      repeat (4) @(posedge clk);
      calDone <= 1'b0;
      repeat (3) @(posedge clk);
      calBiasValue <= ~d;
      m[ADDR_OSC_BIAS_CAL_READBACK] = d;
      repeat (4) @(posedge clk);
      rd(ADDR_OSC_BIAS_CAL_READBACK);
      // strength probe needs both selections at once
      for (int i = 0; i < 8; i++) begin
         s = {6'($urandom), i[1] ? 2'h3 : 2'(i)};
         wr(ADDR_ANALOG_PROBE_SELECT, i[2] ? 8'h64 : 8'h65 + 8'(i));
         wr(ADDR_STRENGTH_PROBE_MUX, s);
         repeat (2) @(negedge clk);
         `CHK(analogProbePinThreeEn, (i[2] && s[1:0] == 2'h3))
      end
      // gain field follows the register, zero on every other write
      foreach (codes[i]) begin
         wr(ADDR_PROBE_DAC_GAIN, i[0] ? 8'h00 : 8'($urandom));
         repeat (2) @(negedge clk);
         `CHK(testDacGain, m[ADDR_PROBE_DAC_GAIN][3:0])
      end
      // every pin code, serial modes and a few unlisted ones with random sources
      for (int k = 0; k < 8'd9; k++) codes.push_back(8'hA0 + 8'(k));
      foreach (codes[k]) begin
         @(posedge clk);
         src <= 8'($urandom);
         dflt <= 5'($urandom);
         wr(ADDR_PIN_FUNCTION_SELECT, codes[k]);
         repeat (5) @(posedge clk);
         @(negedge clk);
         sEn = codes[k] >= 8'hA0 && codes[k] <= 8'hA8;
         `CHK(({sportEn, sportMode}), ({sEn, sEn ? 4'(codes[k] - 8'hA0) : 4'hF}))
         `CHK(testDacEn, (codes[k] == 8'hC9))
         `CHK(pins, expPins(codes[k]))
      end
      // a reset in mid-run brings every register and output back to its reset value
      @(posedge clk);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      modelReset();
      @(negedge clk);
      `CHK(({testDacGain, sportMode, sportEn, analogProbePinThreeEn, testDacEn}), ({4'h4, 4'hF, 3'h0}))
      `CHK(pins, 5'h00)
      foreach (addrs[i]) rd(addrs[i]);
      printVerdict();
   end
endmodule // testbench
